// *** sim/strap_board.sv ***
// Purpose: board pull resistors and indicator lamp beside the sampler
// Assumes: every strap pin has a pull resistor set by the bench
// Notes:   the shared indicator pin shows its pull while undriven
`timescale 1ns/1ps
module strap_board (
	// strap pull levels chosen by the bench
	input  wire logic [1:0] pull_nonrem,
	input  wire logic [2:0] pull_sel,
	// indicator pin as the design drives it
	input  wire logic       ind_level,
	input  wire logic       ind_oe_n,
	// pin levels seen by the design, lamp state
	output logic      [1:0] pin_nonrem,
	output logic      [2:0] pin_sel,
	output logic            lamp_lit
);
	// shared pin: the design's drive wins over the pull resistor
	assign pin_nonrem = pull_nonrem;
	assign pin_sel    = {pull_sel[2], ind_oe_n ? pull_sel[1] : ind_level,
		pull_sel[0]};
	assign lamp_lit   = !ind_oe_n && (ind_level != pull_sel[1]);
endmodule

// *** sim/strap_sampler_bench.sv ***
// Purpose: self-checking bench for the strap sampler
// Assumes: straps stand still across the reset release
// Notes:   a second copy built without the sel2 pin checks the zero
`timescale 1ns/1ps
module strap_sampler_bench;
	logic       sys_clk, rst, nonrem_strap_en, upstream_highspeed;
	logic [1:0] pull_nonrem, pin_nonrem, nonrem_code;
	logic [2:0] pull_sel, pin_sel, nonremovable_ports, config_select;
	logic       straps_valid, ind, ind_oe_n, lamp_lit;
	logic [2:0] cfg_nosel2;
	int         fail_count, checks_done;

	strap_sampler i_dut (.sys_clk(sys_clk), .rst(rst),
		.nonremovable_strap_hi(pin_nonrem[1]),
		.nonremovable_strap_lo(pin_nonrem[0]),
		.config_select_bit0(pin_sel[0]), .config_select_bit1(pin_sel[1]),
		.config_select_bit2(pin_sel[2]), .nonrem_strap_en(nonrem_strap_en),
		.upstream_highspeed(upstream_highspeed), .nonrem_code(nonrem_code),
		.nonremovable_ports(nonremovable_ports),
		.config_select(config_select), .straps_valid(straps_valid),
		.upstream_highspeed_indicator(ind), .indicator_oe_n(ind_oe_n));
	strap_board i_board (.pull_nonrem(pull_nonrem), .pull_sel(pull_sel),
		.ind_level(ind), .ind_oe_n(ind_oe_n), .pin_nonrem(pin_nonrem),
		.pin_sel(pin_sel), .lamp_lit(lamp_lit));
	// same straps into a build without the select bit 2 pin
	strap_sampler #(.HAS_SEL2_PIN(1'b0)) i_dut_nosel2 (.sys_clk(sys_clk),
		.rst(rst), .nonremovable_strap_hi(pin_nonrem[1]),
		.nonremovable_strap_lo(pin_nonrem[0]),
		.config_select_bit0(pin_sel[0]), .config_select_bit1(pin_sel[1]),
		.config_select_bit2(pin_sel[2]), .nonrem_strap_en(nonrem_strap_en),
		.upstream_highspeed(upstream_highspeed), .nonrem_code(),
		.nonremovable_ports(), .config_select(cfg_nosel2),
		.straps_valid(), .upstream_highspeed_indicator(),
		.indicator_oe_n());

	// 250 MHz core clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// reset with straps set, then wait bounded for the take
	task automatic boot(input logic [1:0] nr, input logic en,
		input logic [2:0] sel);
		@(posedge sys_clk);
		#1 rst = 1'b1;
		pull_nonrem = nr;
		pull_sel = sel;
		nonrem_strap_en = en;
		repeat (6) @(posedge sys_clk);
		#1 rst = 1'b0;
		for (int n = 0; n < 10 && straps_valid !== 1'b1; n++) begin
			@(posedge sys_clk);
			#1;
		end
		@(posedge sys_clk);
		#1;
	endtask

	// fixed-port mask expected for a strap code
	function automatic logic [2:0] mask_of(input logic [1:0] c);
		return (c == 2'h0) ? 3'h0 : (c == 2'h1) ? 3'h1 :
			(c == 2'h2) ? 3'h3 : 3'h7;
	endfunction

	// watchdog: eight boots take well under a thousand cycles
	initial begin
		#5000;
		fail_count++;
		test_done();
	end

	initial begin
		logic [1:0] nr;
		logic [1:0] exp_nr;
		logic [2:0] sel;
		logic       exp_ind;
		rst = 1'b1;
		upstream_highspeed = 1'b0;
		nonrem_strap_en = 1'b1;
		pull_nonrem = 2'h0;
		pull_sel = 3'h0;
		fail_count = 0;
		checks_done = 0;
		for (int i = 0; i < 8; i++) begin
			nr = 2'(i);
			sel = 3'(7 - i);
			exp_nr = (i != 5) ? nr : 2'h0;
			boot(nr, i != 5, sel);
			chk({7'h0, straps_valid}, 8'h01);
			chk({6'h0, nonrem_code}, {6'h0, exp_nr});
			chk({5'h0, nonremovable_ports}, {5'h0, mask_of(exp_nr)});
			chk({5'h0, config_select}, {5'h0, sel});
			chk({5'h0, cfg_nosel2}, {5'h0, 1'b0, sel[1:0]});
			for (int hs = 0; hs < 2; hs++) begin
				upstream_highspeed = hs[0];
				exp_ind = sel[1] ? !hs[0] : hs[0];
				repeat (2) @(posedge sys_clk);
				#1 chk({6'h0, ind_oe_n, ind}, {6'h0, 1'b0, exp_ind});
				chk({7'h0, lamp_lit}, {7'h0, hs[0]});
			end
			pull_nonrem = ~nr;
			pull_sel = ~sel;
			repeat (4) @(posedge sys_clk);
			#1 chk({nonremovable_ports, config_select, nonrem_code},
				{mask_of(exp_nr), sel, exp_nr});
		end
		test_done();
	end
endmodule

// *** verilog/pin_sync.sv ***
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: pins are asynchronous to sys_clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// pins in, synchronised out
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync_out
);
	logic [WIDTH-1:0] meta_q;

	// elaboration check: a zero-width bundle has nothing to carry
	if (WIDTH < 1) begin : g_bad_width
		$error("pin_sync width must be at least one");
	end

	// two stages, both cleared by reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_q       <= {WIDTH{strap_pkg::SYNC_RST}};
			pin_sync_out <= {WIDTH{strap_pkg::SYNC_RST}};
		end else begin
			meta_q       <= pin_in;
			pin_sync_out <= meta_q;
		end
	end
endmodule

// *** verilog/strap_pkg.sv ***
// Purpose: shared constants for the strap sampler and speed indicator
// Assumes: one core clock at 250 MHz
// Notes:   strap codes, port masks, reset values, select field positions and settle counter steps
package strap_pkg;
	// non-removable strap codes
	localparam logic [1:0] NONREM_NONE    = 2'h0;
	localparam logic [1:0] NONREM_P1      = 2'h1;
	localparam logic [1:0] NONREM_P12     = 2'h2;
	localparam logic [1:0] NONREM_P123    = 2'h3;
	// decoded port masks, bit 0 is port 1
	localparam logic [2:0] MASK_NONE      = 3'h0;
	localparam logic [2:0] MASK_P1        = 3'h1;
	localparam logic [2:0] MASK_P12       = 3'h3;
	localparam logic [2:0] MASK_P123      = 3'h7;
	// reset values
	localparam logic [1:0] NONREM_RST     = 2'h0;
	localparam logic [2:0] CFG_SEL_RST    = 3'h0;
	localparam logic       SYNC_RST       = 1'h0;
	// field positions inside the select word
	localparam int         CFG_BIT0       = 0;
	localparam int         CFG_BIT1       = 1;
	localparam int         CFG_BIT2       = 2;
	// sampled flag clears in reset
	localparam logic       SAMPLED_RST    = 1'h0;
	// settle counter: take once the synchroniser is refilled
	localparam logic [1:0] SETTLE_RST     = 2'h0;
	localparam logic [1:0] SETTLE_STEP    = 2'h1;
	localparam logic [1:0] SETTLE_DONE    = 2'h2;
	// indicator pin idle level and released enable
	localparam logic       IND_RST        = 1'h0;
	localparam logic       IND_OE_N_RST   = 1'h1;
endpackage

// *** verilog/strap_sampler.sv ***
// Purpose: latch pin straps at reset release, decode fixed ports,
//          drive the upstream high-speed indicator
// Assumes: rst is the core's synchronous view of the reset pin
// Notes:   straps are taken from synchronised pins on the third
//          edge after rst falls, then frozen until the next reset;
//          the indicator pin stays released until then, so only the
//          board pull sets select bit 1
`timescale 1ns/1ps
module strap_sampler #(
	parameter bit HAS_SEL2_PIN = 1'b1
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// strap pins, shared with serial bus and indicators
	input  wire logic       nonremovable_strap_hi,
	input  wire logic       nonremovable_strap_lo,
	input  wire logic       config_select_bit0,
	input  wire logic       config_select_bit1,
	input  wire logic       config_select_bit2,
	// strap enable from package and configuration
	input  wire logic       nonrem_strap_en,
	// upstream link speed from the core
	input  wire logic       upstream_highspeed,
	// latched and decoded results
	output logic [1:0]      nonrem_code,
	output logic [2:0]      nonremovable_ports,
	output logic [2:0]      config_select,
	output logic            straps_valid,
	// indicator pin: level, and enable low while driving
	output logic            upstream_highspeed_indicator,
	output logic            indicator_oe_n
);
	//--------------------------------------------------------------
	// pin synchronisation
	//--------------------------------------------------------------
	logic [4:0] pins_s;
	logic [1:0] nonrem_q;
	logic [1:0] nonrem_d;
	logic [2:0] cfg_q;
	logic [2:0] cfg_d;
	logic [2:0] ports_q;
	logic [2:0] ports_d;
	logic       sampled_q;
	logic       take;
	logic       ind_q;
	logic       ind_d;
	logic       oe_n_q;

	pin_sync #(
		.WIDTH (5)
	) u_sync (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.pin_in       ({config_select_bit2, config_select_bit1,
		                config_select_bit0, nonremovable_strap_hi,
		                nonremovable_strap_lo}),
		.pin_sync_out (pins_s)
	);

	//--------------------------------------------------------------
	// strap decode
	//--------------------------------------------------------------
	// map a two-bit code to the mask of fixed ports
	function automatic logic [2:0] nonrem_mask(input logic [1:0] code);
		logic [2:0] m;
		m = strap_pkg::MASK_NONE;
		unique case (code)
			strap_pkg::NONREM_NONE: m = strap_pkg::MASK_NONE;
			strap_pkg::NONREM_P1:   m = strap_pkg::MASK_P1;
			strap_pkg::NONREM_P12:  m = strap_pkg::MASK_P12;
			strap_pkg::NONREM_P123: m = strap_pkg::MASK_P123;
		endcase
		return m;
	endfunction

	// sample once; the synchroniser was flushed by reset, so pins_s
	// is only trusted two edges after release
	logic [1:0] settle_q;
	assign take = !sampled_q && (settle_q == strap_pkg::SETTLE_DONE);

	// both halves taken together, only when enabled
	assign nonrem_d = (take && nonrem_strap_en) ? pins_s[1:0] : nonrem_q;
	assign ports_d  = nonrem_mask(nonrem_d);
	// serial-clock pin becomes select bit 0
	// indicator pin becomes select bit 1
	// bit 2 forced low when the package lacks it
	assign cfg_d    = take ? {pins_s[4] & HAS_SEL2_PIN, pins_s[3:2]}
	                       : cfg_q;

	// polarity from latched select bit 1
	// asserted at high speed, negated at full speed
	assign ind_d = upstream_highspeed ^ cfg_q[strap_pkg::CFG_BIT1];

	//--------------------------------------------------------------
	// latches
	//--------------------------------------------------------------
	// latched values change only in reset or on the single take; settle_q steps until done
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			nonrem_q  <= strap_pkg::NONREM_RST;
			ports_q   <= strap_pkg::MASK_NONE;
			cfg_q     <= strap_pkg::CFG_SEL_RST;
			sampled_q <= strap_pkg::SAMPLED_RST;
			settle_q  <= strap_pkg::SETTLE_RST;
		end else begin
			nonrem_q  <= nonrem_d;
			ports_q   <= ports_d;
			cfg_q     <= cfg_d;
			if (take)
				sampled_q <= 1'b1;
			if (settle_q != strap_pkg::SETTLE_DONE)
				settle_q <= settle_q + strap_pkg::SETTLE_STEP;
		end
	end

	// indicator is released (input) until straps are known, so the
	// strap resistor is not fought during sampling
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ind_q  <= strap_pkg::IND_RST;
			oe_n_q <= strap_pkg::IND_OE_N_RST;
		end else begin
			ind_q  <= sampled_q ? ind_d : strap_pkg::IND_RST;
			oe_n_q <= !sampled_q;
		end
	end

	// outputs straight from flops
	assign nonrem_code                  = nonrem_q;
	assign nonremovable_ports           = ports_q;
	assign config_select                = cfg_q;
	assign straps_valid                 = sampled_q;
	assign upstream_highspeed_indicator = ind_q;
	assign indicator_oe_n               = oe_n_q;

	//--------------------------------------------------------------
	// checks
	//--------------------------------------------------------------
	// code 00 fixes no port
	decode_none_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		sampled_q && nonrem_q == strap_pkg::NONREM_NONE |->
		ports_q == strap_pkg::MASK_NONE)
		else $error("port mask wrong for code 00");

	decode_low_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		sampled_q && nonrem_q == 2'h1 |-> ports_q == 3'h1)
		else $error("port mask wrong for code 01");

	decode_high_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		sampled_q && nonrem_q[1] |-> ports_q == {nonrem_q[0], 2'h3})
		else $error("port mask wrong for code 1x");

	straps_frozen_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		sampled_q |=> $stable(cfg_q) && $stable(nonrem_q))
		else $error("latched strap changed");

	sel2_absent_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		!HAS_SEL2_PIN |-> !cfg_q[2])
		else $error("select bit 2 set without pin");

	sel2_take_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		take && HAS_SEL2_PIN |=> cfg_q[2] == $past(pins_s[4]))
		else $error("select bit 2 not latched");

	sel0_take_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		take |=> cfg_q[0] == $past(pins_s[2]))
		else $error("select bit 0 not latched");

	sel1_take_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		take |=> cfg_q[1] == $past(pins_s[3]))
		else $error("select bit 1 not latched");

	// both strap halves taken when enabled
	nonrem_take_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		take && nonrem_strap_en |=> nonrem_q == $past(pins_s[1:0]))
		else $error("non-removable strap not latched");

	// disabled strap keeps its reset code
	nonrem_off_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		take && !nonrem_strap_en |=> nonrem_q == strap_pkg::NONREM_RST)
		else $error("non-removable strap taken while disabled");

	// polarity and drive follow the latched bit
	ind_polarity_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		sampled_q ##1 sampled_q |-> !oe_n_q &&
		ind_q == ($past(upstream_highspeed) ^ $past(cfg_q[1])))
		else $error("indicator polarity wrong");

	// pin released until the straps are known
	ind_released_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		!sampled_q |=> oe_n_q && ind_q == strap_pkg::IND_RST)
		else $error("indicator driven before sampling");

	// release sequence takes exactly three edges
	sample_time_a: assert property (@(posedge sys_clk)
		$fell(rst) |-> !sampled_q [*3] ##1 sampled_q)
		else $error("straps not sampled on time");
endmodule
